// >>> shared/mpsc_pkg.sv
package mpsc_pkg;
  // ---------------------------------------------------------------------------
  // dram suspend refresh modes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MPSC_REF_CBR  = 2'b00,
    MPSC_REF_SELF = 2'b01,
    MPSC_REF_OFF  = 2'b10
  } mpsc_dram_mode_t;

  // ---------------------------------------------------------------------------
  // rom suspend options
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MPSC_ROM_HIGH  = 2'b00,
    MPSC_ROM_FLOAT = 2'b01,
    MPSC_ROM_PD    = 2'b10
  } mpsc_rom_mode_t;

  // ---------------------------------------------------------------------------
  // pin state machine
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MPSC_ST_RESET   = 2'b00,
    MPSC_ST_NORMAL  = 2'b01,
    MPSC_ST_SUSPEND = 2'b10
  } mpsc_state_t;

  // ---------------------------------------------------------------------------
  // widths, field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          STRB_W        = 8;
  localparam int          ADDR_W        = 13;
  localparam int          DATA_W        = 16;
  localparam int          CFG_W         = 4;
  localparam int          ROM_W         = 4;
  localparam int          STRAP_W       = 5;
  localparam int          UPPER_LO      = 4;
  localparam int          ADDR_TOP      = 12;
  localparam int          ADDR_TEST     = 4;
  localparam int          ADDR_MID_HI   = 11;
  localparam int          CFG_SDBUF     = 3;
  localparam logic [3:0]  CFG_RST       = 4'h0;
  localparam logic [7:0]  STRB_INACTIVE = 8'hFF;
  localparam logic [12:0] ADDR_OE_ALL   = 13'h1FFF;
  localparam logic [12:0] ADDR_OE_RST   = 13'h1FE0;
  localparam logic [12:0] ADDR_PD_RST   = 13'h001F;
  localparam logic [15:0] DATA_PD_ALL   = 16'hFFFF;
endpackage

// >>> logic/mpsc_top.sv
// How it works
// - suspend with cbr refresh: strobes keep driven by the controller
// - suspend with self refresh: all owned strobes driven low
// - suspend with dram off: strobes and write enable float, pulldown on
// - upper strobe suspend handling only when those strobes own their pins
// - suspend with dram powered: write enable driven high
// - all 16 data pins get pulldowns whenever they are inputs
// - suspend: top address pin floats with pulldown, any refresh mode
// - suspend: address bits 4 to 11 float with pulldowns
// - reset: five low address pins are strap inputs with pulldowns
// - all straps low selects non-test, 8-bit boot rom, no buffer control
// - strap pulldowns off after reset and through normal operation
// - suspend: pulldown on each strap sampled low
// - suspend: strap on address bits 0 to 3 sampled high floats without pulldown
// - suspend: test strap on address bit 4 floats with pulldown
// - rom selects and strobes suspend high, floating, or pulled down
module mpsc_top (
  // clock and reset
  input  wire logic                        CORE_CLK_IN,
  input  wire logic                        RST_N_IN,
  // mode control
  input  wire logic                        SUSPEND_IN,
  input  wire logic [1:0]                  DRAM_SUSP_MODE_IN,
  input  wire logic [1:0]                  ROM_SUSP_MODE_IN,
  input  wire logic [3:0]                  UPPER_STRB_EN_IN,
  // core-side memory controller signals
  input  wire logic [7:0]                  STRB_CORE_IN,
  input  wire logic                        WE_CORE_IN,
  input  wire logic [12:0]                 ADDR_CORE_IN,
  input  wire logic [3:0]                  ROM_CORE_IN,
  input  wire logic                        DATA_DRIVE_IN,
  // strap pin inputs (low address pins)
  input  wire logic [4:0]                  STRAP_PIN_IN,
  // dram strobes: row_strobe 0..3, col_strobe_high 0..1, col_strobe_low 0..1
  output logic [7:0]                       STRB_OUT,
  output logic [7:0]                       STRB_OE_OUT,
  output logic [7:0]                       STRB_PD_OUT,
  output logic                             DRAM_WRITE_ENABLE_OUT,
  output logic                             DRAM_WRITE_ENABLE_OE_OUT,
  output logic                             DRAM_WRITE_ENABLE_PD_OUT,
  // address pins
  output logic [12:0]                      ADDR_OUT,
  output logic [12:0]                      ADDR_OE_OUT,
  output logic [12:0]                      ADDR_PD_OUT,
  // data bus pulldowns
  output logic [15:0]                      DATA_PD_OUT,
  // rom: boot_rom_select, rom_select_1, rom_read_strobe, rom_write_strobe
  output logic [3:0]                       ROM_OUT,
  output logic [3:0]                       ROM_OE_OUT,
  output logic [3:0]                       ROM_PD_OUT,
  // decoded configuration
  output logic [3:0]                       CFG_LATCHED_OUT,
  output logic                             TEST_MODE_OUT,
  output logic                             BOOT_ROM_WIDE_OUT,
  output logic                             SDBUF_CTRL_EN_OUT
);

  // ---------------------------------------------------------------------------
  // pad state
  // ---------------------------------------------------------------------------
  // one vector holds every pad control so all outputs leave the same flop
  typedef struct packed {
    mpsc_pkg::mpsc_state_t st;
    logic [3:0]            cfg;
    logic                  test;
    logic [7:0]            strb;
    logic [7:0]            strb_oe;
    logic [7:0]            strb_pd;
    logic                  we;
    logic                  we_oe;
    logic                  we_pd;
    logic [12:0]           addr;
    logic [12:0]           addr_oe;
    logic [12:0]           addr_pd;
    logic [15:0]           data_pd;
    logic [3:0]            rom;
    logic [3:0]            rom_oe;
    logic [3:0]            rom_pd;
  } mpsc_state_vec_t;

  mpsc_state_vec_t st_ff;
  mpsc_state_vec_t nxt_st;
  logic [7:0]      strb_owned;

  // ---------------------------------------------------------------------------
  // strobe ownership: low four always, upper four when muxed onto their pins
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < mpsc_pkg::STRB_W; g++) begin : g_own
      if (g < mpsc_pkg::UPPER_LO) begin : g_lo
        assign strb_owned[g] = 1'b1;
      end else begin : g_hi
        // without its enable a shared pin keeps no drive and no pulldown
        assign strb_owned[g] = UPPER_STRB_EN_IN[g - mpsc_pkg::UPPER_LO];
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // next pin state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st         = st_ff;
    // normal-operation defaults
    nxt_st.strb    = STRB_CORE_IN;
    nxt_st.strb_oe = strb_owned;
    nxt_st.strb_pd = 8'h00;
    nxt_st.we      = WE_CORE_IN;
    nxt_st.we_oe   = 1'b1;
    nxt_st.we_pd   = 1'b0;
    nxt_st.addr    = ADDR_CORE_IN;
    nxt_st.addr_oe = mpsc_pkg::ADDR_OE_ALL;
    nxt_st.addr_pd = 13'h0000;
    nxt_st.data_pd = DATA_DRIVE_IN ? 16'h0000 : mpsc_pkg::DATA_PD_ALL;
    nxt_st.rom     = ROM_CORE_IN;
    nxt_st.rom_oe  = 4'hF;
    nxt_st.rom_pd  = 4'h0;
    // reset: inactive levels, strap pins opened with pulldowns
    if (!RST_N_IN) begin
      nxt_st.st      = mpsc_pkg::MPSC_ST_RESET;
      nxt_st.cfg     = mpsc_pkg::CFG_RST;
      nxt_st.test    = 1'b0;
      nxt_st.strb    = mpsc_pkg::STRB_INACTIVE;
      nxt_st.we      = 1'b1;
      nxt_st.addr    = 13'h0000;
      nxt_st.addr_oe = mpsc_pkg::ADDR_OE_RST;
      nxt_st.addr_pd = mpsc_pkg::ADDR_PD_RST;
      nxt_st.data_pd = mpsc_pkg::DATA_PD_ALL;
      nxt_st.rom     = 4'hF;
    end else begin
      // capture straps on the first clock after release; pins still pulled
      if (st_ff.st == mpsc_pkg::MPSC_ST_RESET) begin
        nxt_st.cfg  = STRAP_PIN_IN[3:0];
        nxt_st.test = STRAP_PIN_IN[mpsc_pkg::ADDR_TEST];
      end
      nxt_st.st = SUSPEND_IN ? mpsc_pkg::MPSC_ST_SUSPEND : mpsc_pkg::MPSC_ST_NORMAL;
      if (SUSPEND_IN && st_ff.st != mpsc_pkg::MPSC_ST_RESET) begin
        // dram pins follow the programmed refresh mode
        case (mpsc_pkg::mpsc_dram_mode_t'(DRAM_SUSP_MODE_IN))
          mpsc_pkg::MPSC_REF_CBR: begin
            nxt_st.strb    = STRB_CORE_IN;
            nxt_st.strb_oe = strb_owned;
            nxt_st.we      = 1'b1;
          end
          mpsc_pkg::MPSC_REF_SELF: begin
            nxt_st.strb    = 8'h00;
            nxt_st.we      = 1'b1;
          end
          mpsc_pkg::MPSC_REF_OFF: begin
            nxt_st.strb    = 8'h00;
            nxt_st.strb_oe = 8'h00;
            nxt_st.strb_pd = strb_owned;
            nxt_st.we      = 1'b0;
            nxt_st.we_oe   = 1'b0;
            nxt_st.we_pd   = 1'b1;
          end
          default: begin
            // spare code: dram stays powered, strobes left to the controller
            nxt_st.we = 1'b1;
          end
        endcase
        // address pins all float in suspend
        nxt_st.addr    = 13'h0000;
        nxt_st.addr_oe = 13'h0000;
        nxt_st.addr_pd[mpsc_pkg::ADDR_TOP] = 1'b1;
        nxt_st.addr_pd[mpsc_pkg::ADDR_MID_HI:mpsc_pkg::ADDR_TEST] = 8'hFF;
        // pulldown returns only on straps the board left at their default
        nxt_st.addr_pd[3:0] = ~st_ff.cfg;
        // data bus is an input while suspended
        nxt_st.data_pd = mpsc_pkg::DATA_PD_ALL;
        // rom pins follow their own power-down option
        case (mpsc_pkg::mpsc_rom_mode_t'(ROM_SUSP_MODE_IN))
          mpsc_pkg::MPSC_ROM_FLOAT: begin
            nxt_st.rom    = 4'h0;
            nxt_st.rom_oe = 4'h0;
          end
          mpsc_pkg::MPSC_ROM_PD: begin
            nxt_st.rom    = 4'h0;
            nxt_st.rom_oe = 4'h0;
            nxt_st.rom_pd = 4'hF;
          end
          default: begin
            nxt_st.rom = 4'hF;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    st_ff <= nxt_st;
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------------------
  // enables and pulldowns are active high; no output passes through logic
  assign STRB_OUT                 = st_ff.strb;
  assign STRB_OE_OUT              = st_ff.strb_oe;
  assign STRB_PD_OUT              = st_ff.strb_pd;
  assign DRAM_WRITE_ENABLE_OUT    = st_ff.we;
  assign DRAM_WRITE_ENABLE_OE_OUT = st_ff.we_oe;
  assign DRAM_WRITE_ENABLE_PD_OUT = st_ff.we_pd;
  assign ADDR_OUT                 = st_ff.addr;
  assign ADDR_OE_OUT              = st_ff.addr_oe;
  assign ADDR_PD_OUT              = st_ff.addr_pd;
  assign DATA_PD_OUT              = st_ff.data_pd;
  assign ROM_OUT                  = st_ff.rom;
  assign ROM_OE_OUT               = st_ff.rom_oe;
  assign ROM_PD_OUT               = st_ff.rom_pd;
  assign CFG_LATCHED_OUT          = st_ff.cfg;
  // all-low straps give the default configuration
  assign TEST_MODE_OUT            = st_ff.test;
  assign BOOT_ROM_WIDE_OUT        = st_ff.cfg[0];
  assign SDBUF_CTRL_EN_OUT        = st_ff.cfg[mpsc_pkg::CFG_SDBUF];

endmodule

// >>> test/mpsc_assertions.sv
module mpsc_assertions (
  // clock, reset and controls
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        SUSPEND_IN,
  input wire logic        DATA_DRIVE_IN,
  input wire logic [1:0]  DRAM_SUSP_MODE_IN,
  input wire logic [1:0]  ROM_SUSP_MODE_IN,
  input wire logic [3:0]  UPPER_STRB_EN_IN,
  input wire logic [7:0]  STRB_CORE_IN,
  // pad controls
  input wire logic        DRAM_WRITE_ENABLE_OUT,
  input wire logic        DRAM_WRITE_ENABLE_OE_OUT,
  input wire logic [3:0]  ROM_OUT,
  input wire logic [3:0]  ROM_OE_OUT,
  input wire logic [3:0]  ROM_PD_OUT,
  input wire logic [3:0]  CFG_LATCHED_OUT,
  input wire logic [7:0]  STRB_OUT,
  input wire logic [7:0]  STRB_OE_OUT,
  input wire logic [7:0]  STRB_PD_OUT,
  input wire logic [12:0] ADDR_OE_OUT,
  input wire logic [12:0] ADDR_PD_OUT,
  input wire logic [15:0] DATA_PD_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // suspend is ignored on the first edge after release, so count edges
  logic [1:0] live_ff;
  // inputs as the design took them one edge back
  logic       susp_ff;
  logic       drive_ff;
  logic [1:0] dmode_ff;
  logic [1:0] rmode_ff;
  logic [7:0] owned_ff;
  logic [7:0] core_ff;
  logic       susp_on;
  always_ff @(posedge CORE_CLK_IN) begin
    live_ff  <= !RST_N_IN ? 2'h0 : live_ff + 2'(live_ff != 2'h3);
    susp_ff  <= SUSPEND_IN;
    drive_ff <= DATA_DRIVE_IN;
    dmode_ff <= DRAM_SUSP_MODE_IN;
    rmode_ff <= ROM_SUSP_MODE_IN;
    owned_ff <= {UPPER_STRB_EN_IN, 4'hF};
    core_ff  <= STRB_CORE_IN;
  end
  assign susp_on = live_ff[1] && susp_ff;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  cbr_live_a: assert property (susp_on && dmode_ff == 2'h0
    |-> ((STRB_OUT ^ core_ff) & owned_ff) == 8'h00)
    else $error("strobes not live in cbr suspend");
  self_low_a: assert property (susp_on && dmode_ff == 2'h1
    |-> (STRB_OUT & owned_ff) == 8'h00)
    else $error("strobes not low in self refresh");
  dram_off_a: assert property (susp_on && dmode_ff == 2'h2
    |-> STRB_OE_OUT == 8'h00 && STRB_PD_OUT == owned_ff)
    else $error("strobes not floated with pulldown");
  we_high_a: assert property (susp_on && dmode_ff != 2'h2
    |-> DRAM_WRITE_ENABLE_OUT && DRAM_WRITE_ENABLE_OE_OUT)
    else $error("write enable not driven high");
  addr_float_a: assert property (susp_on
    |-> ADDR_OE_OUT == 13'h0 && ADDR_PD_OUT[12:4] == 9'h1FF)
    else $error("address pins not floated with pulldown");
  strap_pd_a: assert property (susp_on
    |-> ADDR_PD_OUT[3:0] == ~CFG_LATCHED_OUT)
    else $error("strap pulldowns wrong in suspend");
  norm_pd_a: assert property (live_ff[1] && !susp_ff |-> ADDR_PD_OUT == 13'h0)
    else $error("strap pulldowns on in normal run");
  rom_high_a: assert property (susp_on && rmode_ff == 2'h0
    |-> ROM_OUT == 4'hF && ROM_OE_OUT == 4'hF)
    else $error("rom pins not driven high");
  rom_float_a: assert property (susp_on && rmode_ff == 2'h1
    |-> ROM_OE_OUT == 4'h0 && ROM_PD_OUT == 4'h0)
    else $error("rom pins not floated bare");
  rom_pd_a: assert property (susp_on && rmode_ff == 2'h2
    |-> ROM_OE_OUT == 4'h0 && ROM_PD_OUT == 4'hF)
    else $error("rom pins not pulled down");
  data_pd_a: assert property (live_ff[1] && !drive_ff |-> DATA_PD_OUT == 16'hFFFF)
    else $error("data pulldowns off while input");
  reset_strap_a: assert property ($past(!RST_N_IN) |-> ADDR_PD_OUT == 13'h001F)
    else $error("strap pulldowns off in reset");
  cfg_hold_a: assert property (live_ff[1] |-> $stable(CFG_LATCHED_OUT))
    else $error("latched straps changed");
endmodule

bind mpsc_top mpsc_assertions mpsc_assertions_i (.*);

// >>> test/mpsc_strap_board.sv
module mpsc_strap_board (
  // clock and board fitting
  input  wire logic       clk_in,
  input  wire logic [3:0] pullup_in,
  // pad controls of the five strap pins
  input  wire logic [4:0] oe_in,
  input  wire logic [4:0] pd_in,
  input  wire logic [4:0] out_in,
  // level seen at the pins
  output logic      [4:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wobble_ff = 1'b0;
  logic [4:0] pu;
  // test strap never gets a board pullup
  assign pu = {1'b0, pullup_in};
  always @(posedge clk_in) begin
    wobble_ff <= !wobble_ff;
  end
  // a floating pin wanders rather than keeping a stale level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_out[i] = oe_in[i] ? out_in[i] : pu[i] ? 1'b1 : pd_in[i] ? 1'b0 : wobble_ff ^ i[0];
    end
  end
endmodule

// >>> test/test_memory_pin_suspend_state_ctrl.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_memory_pin_suspend_state_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK_IN = 1'b0, RST_N_IN = 1'b0, SUSPEND_IN = 1'b0, DATA_DRIVE_IN = 1'b0;
  logic WE_CORE_IN = 1'b0, we, we_oe, we_pd, tst, wide, sdb;
  logic [1:0] DRAM_SUSP_MODE_IN = 2'h0, ROM_SUSP_MODE_IN = 2'h0;
  logic [3:0] UPPER_STRB_EN_IN = 4'h0, ROM_CORE_IN = 4'h0, pu = 4'h0, rom, rom_oe, rom_pd, cfg;
  logic [7:0] STRB_CORE_IN = 8'h0, strb, strb_oe, strb_pd;
  logic [12:0] ADDR_CORE_IN = 13'h0, addr, addr_oe, addr_pd;
  logic [4:0] strap;
  logic [15:0] data_pd;
  logic [31:0] seed = 32'h4e2a_b405, rnd;
  logic [74:0] got, want;
  logic [25:0] gotv, wantv;
  logic [100:0] notes[$];
  int fail_count = 0, check_count = 0, live = 0, cycles = 0;
  always #50 CORE_CLK_IN = !CORE_CLK_IN;
  mpsc_top mpsc_top_i (.CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .SUSPEND_IN(SUSPEND_IN),
    .DRAM_SUSP_MODE_IN(DRAM_SUSP_MODE_IN), .ROM_SUSP_MODE_IN(ROM_SUSP_MODE_IN),
    .UPPER_STRB_EN_IN(UPPER_STRB_EN_IN), .STRB_CORE_IN(STRB_CORE_IN), .WE_CORE_IN(WE_CORE_IN),
    .ADDR_CORE_IN(ADDR_CORE_IN), .ROM_CORE_IN(ROM_CORE_IN), .DATA_DRIVE_IN(DATA_DRIVE_IN),
    .STRAP_PIN_IN(strap), .STRB_OUT(strb), .STRB_OE_OUT(strb_oe), .STRB_PD_OUT(strb_pd),
    .DRAM_WRITE_ENABLE_OUT(we), .DRAM_WRITE_ENABLE_OE_OUT(we_oe),
    .DRAM_WRITE_ENABLE_PD_OUT(we_pd), .ADDR_OUT(addr), .ADDR_OE_OUT(addr_oe),
    .ADDR_PD_OUT(addr_pd), .DATA_PD_OUT(data_pd), .ROM_OUT(rom), .ROM_OE_OUT(rom_oe),
    .ROM_PD_OUT(rom_pd), .CFG_LATCHED_OUT(cfg), .TEST_MODE_OUT(tst),
    .BOOT_ROM_WIDE_OUT(wide), .SDBUF_CTRL_EN_OUT(sdb));
  mpsc_strap_board mpsc_strap_board_i (.clk_in(CORE_CLK_IN), .pullup_in(pu),
    .oe_in(addr_oe[4:0]), .pd_in(addr_pd[4:0]), .out_in(addr[4:0]), .pin_out(strap));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [100:0] expect_v(input logic r, s, input logic [1:0] dm, rm,
      input logic [3:0] up, input logic dd, input logic [3:0] c, input logic [7:0] sc,
      input logic wc, input logic [12:0] ac, input logic [3:0] rc);
    logic off;
    logic lowstrb;
    logic romoff;
    off = s && dm == 2'h2;
    lowstrb = s && dm inside {2'h1, 2'h2};
    romoff = s && rm inside {2'h1, 2'h2};
    return {r ? 13'h1FE0 : s ? 13'h0 : 13'h1FFF, r ? 13'h001F : s ? {9'h1FF, ~c} : 13'h0,
      off ? 8'h0 : {up, 4'hF}, off ? {up, 4'hF} : 8'h0, (r | s | !dd) ? 16'hFFFF : 16'h0,
      romoff ? 4'h0 : 4'hF, (s && rm == 2'h2) ? 4'hF : 4'h0,
      !off, off, c, 1'b0, c[0], c[3],
      (r | s) ? 13'h0 : ac, r ? 8'hFF : lowstrb ? 8'h0 : sc, r ? 1'b1 : s ? !off : wc,
      r ? 4'hF : romoff ? 4'h0 : s ? 4'hF : rc};
  endfunction
  task step(input logic r);
    @(negedge CORE_CLK_IN);
    rnd = xs();
    {SUSPEND_IN, DRAM_SUSP_MODE_IN, ROM_SUSP_MODE_IN, UPPER_STRB_EN_IN, DATA_DRIVE_IN,
      WE_CORE_IN} = rnd[10:0];
    {STRB_CORE_IN, ADDR_CORE_IN, ROM_CORE_IN} = rnd[31:7];
    RST_N_IN = !r;
    notes.push_back(expect_v(r, !r && SUSPEND_IN && live > 0, DRAM_SUSP_MODE_IN,
      ROM_SUSP_MODE_IN, UPPER_STRB_EN_IN, DATA_DRIVE_IN, r ? 4'h0 : pu, STRB_CORE_IN,
      WE_CORE_IN, ADDR_CORE_IN, ROM_CORE_IN));
    live = r ? 0 : live + 1;
  endtask
  task report_and_stop();
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge CORE_CLK_IN) begin
    #1;
    cycles++;
    if (notes.size() > 0) begin
      got = {addr_oe, addr_pd, strb_oe, strb_pd, data_pd, rom_oe, rom_pd, we_oe, we_pd,
        cfg, tst, wide, sdb};
      gotv = {addr, strb, we, rom};
      {want, wantv} = notes.pop_front();
      `CHK(got, want)
      `CHK(gotv, wantv)
    end
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // first pass keeps every strap at its default, second fits board pullups
  initial begin
    for (int k = 0; k < 2; k++) begin
      rnd = xs();
      pu = k == 0 ? 4'h0 : rnd[3:0] | 4'h1;
      repeat (8) step(1'b1);
      repeat (300) step(1'b0);
    end
    @(posedge CORE_CLK_IN);
    #2;
    report_and_stop();
  end
endmodule
